// ==== common/frwh_pkg.sv ====
package frwh_pkg;
  // Monitor codes.
  localparam logic [15:0] MON_NONE0 = 16'h0000;
  localparam logic [15:0] MON_OUT_FREQ = 16'h0001;
  localparam logic [15:0] MON_OUT_CURR = 16'h0002;
  localparam logic [15:0] MON_OUT_VOLT = 16'h0003;
  localparam logic [15:0] MON_NONE4 = 16'h0004;
  localparam logic [15:0] MON_SPEED_SET = 16'h0005;
  localparam logic [15:0] MON_OP_SPEED = 16'h0006;
  localparam logic [15:0] MON_TORQUE_CMD = 16'h0007;
  localparam logic [15:0] MON_DC_BUS = 16'h0008;
  localparam logic [15:0] MON_GAP1_LO = 16'h0009;
  localparam logic [15:0] MON_GAP1_HI = 16'h000D;
  localparam logic [15:0] MON_MOTOR_PWR = 16'h000E;
  localparam logic [15:0] MON_OP_CMD = 16'h000F;
  localparam logic [15:0] MON_OUT_TERM = 16'h0010;
  localparam logic [15:0] MON_TQ_CURR = 16'h0011;
  localparam logic [15:0] MON_FLUX = 16'h0012;
  localparam logic [15:0] MON_ENC_POS = 16'h0013;
  localparam logic [15:0] MON_ON_HOURS = 16'h0014;
  localparam logic [15:0] MON_GAP2_LO = 16'h0015;
  localparam logic [15:0] MON_GAP2_HI = 16'h0019;
  // Command codes.
  localparam logic [15:0] CMD_PAR_RD_HI = 16'h0063;
  localparam logic [15:0] CMD_ALM_H12 = 16'h0074;
  localparam logic [15:0] CMD_ALM_H78 = 16'h0077;
  localparam logic [15:0] CMD_MODE_RD = 16'h007B;
  localparam logic [15:0] CMD_SPD_RD = 16'h006D;
  localparam logic [15:0] CMD_EXT_RD = 16'h007F;
  localparam logic [15:0] CMD_PAR_WR_LO = 16'h0080;
  localparam logic [15:0] CMD_PAR_WR_HI = 16'h00E3;
  localparam logic [15:0] CMD_SPD_WR = 16'h00ED;
  localparam logic [15:0] CMD_MODE_WR = 16'h00FB;
  localparam logic [15:0] CMD_ALM_RESET = 16'h00FD;
  localparam logic [15:0] CMD_EXT_WR = 16'h00FF;
  localparam logic [15:0] ALM_RESET_KEY = 16'h9696;
  localparam logic [15:0] PAR_WR_OFS = 16'h0080;
  // Response codes.
  localparam logic [15:0] RSP_OK = 16'h0000;
  localparam logic [15:0] RSP_BAD_CODE = 16'h0001;
  localparam logic [15:0] RSP_BAD_DATA = 16'h0002;
  localparam logic [15:0] RSP_BAD_MODE = 16'h0003;
  // Operating modes.
  localparam logic [15:0] MODE_LINK = 16'h0000;
  localparam logic [15:0] MODE_TERMINAL = 16'h0001;
  // Speed scale limits.
  localparam logic signed [15:0] SPEED_MAX = 16'sh4E20;
  localparam logic signed [15:0] SPEED_MIN = -16'sh4E20;
  // Parameter store.
  localparam int PAR_DEPTH = 256;
  localparam int PAR_AW = 8;
  localparam logic [7:0] PAR_LIMIT = 8'h63;
  // Timing: one hour at 200 MHz.
  localparam longint CLK_HZ = 200000000;
  localparam longint HOUR_S = 3600;
  localparam longint HOUR_CYCLES = CLK_HZ * HOUR_S;
  localparam logic [1:0] ENC_STEP_FWD = 2'h1;
  localparam logic [1:0] ENC_STEP_REV = 2'h3;
endpackage

// ==== src/frwh_sync2.sv ====
`timescale 1ns/1ps
module frwh_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end
  assign o_q = q_r;
endmodule // frwh_sync2

// ==== src/frwh_quad_count.sv ====
`timescale 1ns/1ps
// Quadrature position counter, one count per edge of either channel.
module frwh_quad_count (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  output logic [15:0] o_count
);
  logic [1:0] prev_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  wire [1:0] cur = {i_enc_a, i_enc_b};
  wire [1:0] gray_prev = {prev_r[1], prev_r[1] ^ prev_r[0]};
  wire [1:0] gray_cur = {cur[1], cur[1] ^ cur[0]};
  wire [1:0] step = gray_cur - gray_prev;
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (step == frwh_pkg::ENC_STEP_FWD)
      cnt_nxt = cnt_r + 16'h0001;
    else if (step == frwh_pkg::ENC_STEP_REV)
      cnt_nxt = cnt_r - 16'h0001;
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_r <= 2'h0;
      cnt_r <= 16'h0000;
    end
    else
    begin
      prev_r <= cur;
      cnt_r <= cnt_nxt;
    end
  end
  assign o_count = cnt_r;
endmodule // frwh_quad_count

// ==== src/frwh_remote_words.sv ====
// Contract
// - Monitor request copies the selected quantity into the monitored result word.
// - Speed-write request accepts signed reference within plus or minus 20000.
// - Device raises speed-write done once reference is accepted.
// - Actual speed word refreshed continuously, 20000 equals maximum speed.
// - Commands cover mode rewrite, parameter read/write, alarm history, alarm reset.
// - Command-execute request runs the command held in command select.
// - Device raises command-done when execution finishes.
// - Response code zero on success, nonzero on incorrect data.
// - On success the command's response data goes to the result word.
// - Command writes touch volatile parameters only; save-all persists them.
// - Monitor codes 0, 4, 9..D and 15..19 read as zero.
// - Monitor code 13 returns fourfold encoder position count.
// - Monitor code 14 returns powered-on hours.
// - Monitor code 11 returns torque-current command in 0.1 percent.
// - Command-done rises only after command processing fully completes; a parameter write reaches the store one cycle after done rises.
// - Alarm reset acts only with argument 9696 and during link operation.
`timescale 1ns/1ps
module frwh_remote_words #(
  parameter longint HOUR_CYCLES = frwh_pkg::HOUR_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Words written by the master, held by the link layer.
  input wire logic [15:0] i_monitor_selector,
  input wire logic [15:0] i_speed_reference,
  input wire logic [15:0] i_command_select,
  input wire logic [15:0] i_command_argument,
  input wire logic i_monitor_request,
  input wire logic i_speed_write_request,
  input wire logic i_cmd_exec_request,
  // Drive quantities sampled for the monitor.
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_out_curr,
  input wire logic [15:0] i_out_volt,
  input wire logic [15:0] i_op_speed_rpm,
  input wire logic [15:0] i_torque_cmd,
  input wire logic [15:0] i_dc_bus,
  input wire logic [15:0] i_motor_pwr,
  input wire logic [15:0] i_op_cmd_bits,
  input wire logic [15:0] i_out_term_bits,
  input wire logic [15:0] i_torque_curr_cmd,
  input wire logic [15:0] i_flux_cmd,
  input wire logic [15:0] i_motor_speed_scaled,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_link_enable,
  input wire logic [15:0] i_alarm_hist_0,
  input wire logic [15:0] i_alarm_hist_1,
  input wire logic [15:0] i_alarm_hist_2,
  input wire logic [15:0] i_alarm_hist_3,
  input wire logic i_save_all_params,
  output logic [15:0] o_monitored_result,
  output logic [15:0] o_actual_speed,
  output logic [15:0] o_command_response,
  output logic [15:0] o_command_result,
  output logic o_monitor_done,
  output logic o_speed_write_done,
  output logic o_cmd_exec_done,
  output logic [15:0] o_speed_setpoint,
  output logic [15:0] o_operating_mode,
  output logic o_alarm_reset,
  output logic o_save_strobe,
  output logic [15:0] o_param_wr_data,
  output logic [7:0] o_param_wr_addr,
  output logic [7:0] o_link_param_ext
);
  typedef enum logic [1:0] {CMD_IDLE, CMD_EXEC, CMD_DONE} frwh_cmd_state_t;

  // Request and encoder pins arrive from other logic domains.
  logic [5:0] sync_q;
  frwh_sync2 #(.W(6)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_d({i_monitor_request, i_speed_write_request, i_cmd_exec_request,
          i_enc_a, i_enc_b, i_save_all_params}),
    .o_q(sync_q)
  );
  wire mon_req = sync_q[5];
  wire spd_req = sync_q[4];
  wire cmd_req = sync_q[3];
  wire save_req = sync_q[0];

  logic [15:0] enc_count;
  frwh_quad_count u_quad (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_enc_a(sync_q[2]),
    .i_enc_b(sync_q[1]),
    .o_count(enc_count)
  );

  // Powered-on hour counter.
  logic [63:0] hour_tick_r;
  logic [15:0] hours_r;
  wire hour_wrap = (hour_tick_r == 64'(HOUR_CYCLES - 1));
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hour_tick_r <= 64'h0;
      hours_r <= 16'h0000;
    end
    else
    begin
      hour_tick_r <= hour_wrap ? 64'h0 : hour_tick_r + 64'h1;
      if (hour_wrap)
        hours_r <= hours_r + 16'h0001;
    end
  end

  // Monitor selection.
  logic [15:0] speed_set_r;
  logic [15:0] mon_value;
  wire [15:0] sel = i_monitor_selector;
  wire mon_zero = (sel == frwh_pkg::MON_NONE0) || (sel == frwh_pkg::MON_NONE4)
    || (sel >= frwh_pkg::MON_GAP1_LO && sel <= frwh_pkg::MON_GAP1_HI)
    || (sel >= frwh_pkg::MON_GAP2_LO && sel <= frwh_pkg::MON_GAP2_HI);
  always_comb
  begin
    mon_value = 16'h0000;
    if (!mon_zero)
    begin
      case (sel)
        frwh_pkg::MON_OUT_FREQ: mon_value = i_out_freq;
        frwh_pkg::MON_OUT_CURR: mon_value = i_out_curr;
        frwh_pkg::MON_OUT_VOLT: mon_value = i_out_volt;
        frwh_pkg::MON_SPEED_SET: mon_value = speed_set_r;
        frwh_pkg::MON_OP_SPEED: mon_value = i_op_speed_rpm;
        frwh_pkg::MON_TORQUE_CMD: mon_value = i_torque_cmd;
        frwh_pkg::MON_DC_BUS: mon_value = i_dc_bus;
        frwh_pkg::MON_MOTOR_PWR: mon_value = i_motor_pwr;
        frwh_pkg::MON_OP_CMD: mon_value = i_op_cmd_bits;
        frwh_pkg::MON_OUT_TERM: mon_value = i_out_term_bits;
        frwh_pkg::MON_TQ_CURR: mon_value = i_torque_curr_cmd;
        frwh_pkg::MON_FLUX: mon_value = i_flux_cmd;
        frwh_pkg::MON_ENC_POS: mon_value = enc_count;
        frwh_pkg::MON_ON_HOURS: mon_value = hours_r;
        default: mon_value = 16'h0000;
      endcase
    end
  end

  // Monitor handshake: result refreshes while request is held.
  logic [15:0] mon_r;
  logic mon_done_r;
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mon_r <= 16'h0000;
      mon_done_r <= 1'b0;
    end
    else
    begin
      if (mon_req)
        mon_r <= mon_value;
      mon_done_r <= mon_req;
    end
  end

  // Speed reference write.
  logic spd_done_r;
  logic [15:0] actual_r;
  wire signed [15:0] spd_in = i_speed_reference;
  wire spd_in_range = (spd_in <= frwh_pkg::SPEED_MAX) && (spd_in >= frwh_pkg::SPEED_MIN);
  wire signed [15:0] spd_clip = spd_in_range ? spd_in
    : (spd_in[15] ? frwh_pkg::SPEED_MIN : frwh_pkg::SPEED_MAX);

  // Command engine.
  frwh_cmd_state_t st_r;
  logic [15:0] rsp_r;
  logic [15:0] res_r;
  logic [15:0] mode_r;
  logic [7:0] ext_r;
  logic alm_rst_r;
  logic par_we_r;
  logic [7:0] par_wa_r;
  logic [15:0] par_wd_r;
  logic [15:0] par_mem [0:frwh_pkg::PAR_DEPTH-1];
  logic [15:0] c_rsp;
  logic [15:0] c_res;
  wire [15:0] code = i_command_select;
  wire [15:0] arg = i_command_argument;
  wire [7:0] par_rd_idx = code[7:0];
  wire [7:0] par_wr_idx = 8'(code - frwh_pkg::PAR_WR_OFS);
  wire is_par_rd = (code <= frwh_pkg::CMD_PAR_RD_HI);
  wire is_par_wr = (code >= frwh_pkg::CMD_PAR_WR_LO) && (code <= frwh_pkg::CMD_PAR_WR_HI);
  wire is_alm_hist = (code >= frwh_pkg::CMD_ALM_H12) && (code <= frwh_pkg::CMD_ALM_H78);
  wire link_mode = i_link_enable && (mode_r == frwh_pkg::MODE_LINK);
  wire alm_ok = (arg == frwh_pkg::ALM_RESET_KEY) && link_mode;
  wire signed [15:0] arg_s = arg;
  wire arg_spd_ok = (arg_s <= frwh_pkg::SPEED_MAX) && (arg_s >= frwh_pkg::SPEED_MIN);
  wire do_cmd_wr = (st_r == CMD_EXEC) && (c_rsp == frwh_pkg::RSP_OK);

  always_comb
  begin
    c_rsp = frwh_pkg::RSP_OK;
    c_res = 16'h0000;
    if (is_par_rd)
      c_res = par_mem[{ext_r[0], par_rd_idx[6:0]}];
    else if (is_par_wr)
      c_res = 16'h0000;
    else if (is_alm_hist)
    begin
      case (code[1:0])
        2'h0: c_res = i_alarm_hist_0;
        2'h1: c_res = i_alarm_hist_1;
        2'h2: c_res = i_alarm_hist_2;
        default: c_res = i_alarm_hist_3;
      endcase
    end
    else
    begin
      case (code)
        frwh_pkg::CMD_MODE_RD: c_res = mode_r;
        frwh_pkg::CMD_SPD_RD: c_res = speed_set_r;
        frwh_pkg::CMD_EXT_RD: c_res = {8'h00, ext_r};
        frwh_pkg::CMD_SPD_WR: c_rsp = arg_spd_ok ? frwh_pkg::RSP_OK : frwh_pkg::RSP_BAD_DATA;
        frwh_pkg::CMD_MODE_WR:
          c_rsp = (arg == frwh_pkg::MODE_LINK || arg == frwh_pkg::MODE_TERMINAL)
            ? frwh_pkg::RSP_OK : frwh_pkg::RSP_BAD_DATA;
        frwh_pkg::CMD_ALM_RESET:
          c_rsp = alm_ok ? frwh_pkg::RSP_OK
            : (link_mode ? frwh_pkg::RSP_BAD_DATA : frwh_pkg::RSP_BAD_MODE);
        frwh_pkg::CMD_EXT_WR: c_rsp = (arg[15:8] == 8'h00) ? frwh_pkg::RSP_OK
          : frwh_pkg::RSP_BAD_DATA;
        default: c_rsp = frwh_pkg::RSP_BAD_CODE;
      endcase
    end
  end

  // Volatile parameter store; writes never reach non-volatile memory here.
  always_ff @(posedge i_clk_sys)
  begin
    if (par_we_r)
      par_mem[par_wa_r] <= par_wd_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      speed_set_r <= 16'h0000;
      spd_done_r <= 1'b0;
      actual_r <= 16'h0000;
      st_r <= CMD_IDLE;
      rsp_r <= 16'h0000;
      res_r <= 16'h0000;
      mode_r <= frwh_pkg::MODE_LINK;
      ext_r <= 8'h00;
      alm_rst_r <= 1'b0;
      par_we_r <= 1'b0;
      par_wa_r <= 8'h00;
      par_wd_r <= 16'h0000;
    end
    else
    begin
      actual_r <= i_motor_speed_scaled;
      spd_done_r <= spd_req;
      alm_rst_r <= 1'b0;
      par_we_r <= 1'b0;
      if (spd_req && !spd_done_r)
        speed_set_r <= spd_clip;
      case (st_r)
        CMD_IDLE:
          if (cmd_req)
            st_r <= CMD_EXEC;
        CMD_EXEC:
        begin
          rsp_r <= c_rsp;
          if (c_rsp == frwh_pkg::RSP_OK)
            res_r <= c_res;
          if (do_cmd_wr && is_par_wr)
          begin
            par_we_r <= 1'b1;
            par_wa_r <= {ext_r[0], par_wr_idx[6:0]};
            par_wd_r <= arg;
          end
          if (do_cmd_wr && code == frwh_pkg::CMD_SPD_WR)
            speed_set_r <= arg;
          if (do_cmd_wr && code == frwh_pkg::CMD_MODE_WR)
            mode_r <= arg;
          if (do_cmd_wr && code == frwh_pkg::CMD_EXT_WR)
            ext_r <= arg[7:0];
          if (do_cmd_wr && code == frwh_pkg::CMD_ALM_RESET)
            alm_rst_r <= 1'b1;
          st_r <= CMD_DONE;
        end
        CMD_DONE:
          if (!cmd_req)
            st_r <= CMD_IDLE;
        default: st_r <= CMD_IDLE;
      endcase
    end
  end

  assign o_monitored_result = mon_r;
  assign o_actual_speed = actual_r;
  assign o_command_response = rsp_r;
  assign o_command_result = res_r;
  assign o_monitor_done = mon_done_r;
  assign o_speed_write_done = spd_done_r;
  assign o_cmd_exec_done = (st_r == CMD_DONE) && cmd_req;
  assign o_speed_setpoint = speed_set_r;
  assign o_operating_mode = mode_r;
  assign o_alarm_reset = alm_rst_r;
  assign o_save_strobe = save_req;
  assign o_param_wr_data = par_wd_r;
  assign o_param_wr_addr = par_wa_r;
  assign o_link_param_ext = ext_r;
endmodule // frwh_remote_words

// ==== testbench/frwh_remote_words_properties.sv ====
`timescale 1ns/1ps
module frwh_remote_words_properties #(
  parameter longint HOUR_CYCLES = frwh_pkg::HOUR_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [15:0] i_monitor_selector,
  input wire logic [15:0] i_command_select,
  input wire logic [15:0] i_command_argument,
  input wire logic i_monitor_request,
  input wire logic i_speed_write_request,
  input wire logic i_cmd_exec_request,
  input wire logic [15:0] i_motor_speed_scaled,
  input wire logic i_link_enable,
  input wire logic i_save_all_params,
  input wire logic [15:0] o_monitored_result,
  input wire logic [15:0] o_actual_speed,
  input wire logic o_monitor_done,
  input wire logic o_speed_write_done,
  input wire logic o_cmd_exec_done,
  input wire logic [15:0] o_operating_mode,
  input wire logic o_alarm_reset,
  input wire logic o_save_strobe
);
  wire zero_sel = i_monitor_selector inside {16'h0000, 16'h0004, [16'h0009:16'h000D],
    [16'h0015:16'h0019]};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  mon_done_time_a: assert property (
    $rose(i_monitor_request) |-> ##[2:4] o_monitor_done)
    else $error("monitor done missing");
  spd_done_time_a: assert property (
    $rose(i_speed_write_request) |-> ##[2:4] o_speed_write_done)
    else $error("speed write done missing");
  cmd_done_time_a: assert property (
    $rose(i_cmd_exec_request) |-> ##[2:6] o_cmd_exec_done)
    else $error("command done missing");
  cmd_done_drop_a: assert property (
    $fell(i_cmd_exec_request) |-> ##[1:4] !o_cmd_exec_done)
    else $error("command done stuck");
  speed_refresh_a: assert property (
    $past(i_arst_n) |-> o_actual_speed == $past(i_motor_speed_scaled))
    else $error("actual speed not refreshed");
  mon_zero_a: assert property (
    o_monitor_done && $past(o_monitor_done) && zero_sel |-> o_monitored_result == 16'h0000)
    else $error("unused monitor code not zero");
  alarm_key_a: assert property (
    o_alarm_reset |-> i_command_select == 16'h00FD && i_command_argument == 16'h9696
    && i_link_enable)
    else $error("alarm reset without key or link");
  alarm_pulse_a: assert property (
    $rose(o_cmd_exec_done) && i_command_select == 16'h00FD && i_command_argument == 16'h9696
    && i_link_enable && o_operating_mode == 16'h0000 |-> o_alarm_reset)
    else $error("alarm reset not issued");
  save_follow_a: assert property (
    i_save_all_params [*3] |=> o_save_strobe)
    else $error("save strobe missing");
endmodule // frwh_remote_words_properties

bind frwh_remote_words frwh_remote_words_properties #(.HOUR_CYCLES(HOUR_CYCLES))
  frwh_remote_words_properties_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_monitor_selector(i_monitor_selector), .i_command_select(i_command_select),
  .i_command_argument(i_command_argument), .i_monitor_request(i_monitor_request),
  .i_speed_write_request(i_speed_write_request), .i_cmd_exec_request(i_cmd_exec_request),
  .i_motor_speed_scaled(i_motor_speed_scaled), .i_link_enable(i_link_enable),
  .i_save_all_params(i_save_all_params), .o_monitored_result(o_monitored_result),
  .o_actual_speed(o_actual_speed), .o_monitor_done(o_monitor_done),
  .o_speed_write_done(o_speed_write_done), .o_cmd_exec_done(o_cmd_exec_done),
  .o_alarm_reset(o_alarm_reset), .o_save_strobe(o_save_strobe),
  .o_operating_mode(o_operating_mode));

// ==== testbench/frwh_master_model.sv ====
`timescale 1ns/1ps
module frwh_master_model (
  input wire logic i_clk_sys,
  input wire logic [2:0] i_done,
  output logic [15:0] o_sel,
  output logic [15:0] o_spd,
  output logic [15:0] o_cmd,
  output logic [15:0] o_arg,
  output logic [2:0] o_req
);
  initial
  begin
    {o_sel, o_spd, o_cmd, o_arg} = '0;
    o_req = 3'h0;
  end
  // Kind 0 is a monitor read, 1 a speed write, 2 a command; hold stretches the request.
  task automatic xfer(input int k, input logic [15:0] a, input logic [15:0] b, input int hold);
    int n;
    @(negedge i_clk_sys);
    if (k == 0)
      o_sel = a;
    else if (k == 1)
      o_spd = a;
    else
    begin
      o_cmd = a;
      o_arg = b;
    end
    @(negedge i_clk_sys);
    o_req[k] = 1'b1;
    for (n = 0; n < 40 && !i_done[k]; n++)
      @(negedge i_clk_sys);
    repeat (hold + 1) @(negedge i_clk_sys);
    o_req[k] = 1'b0;
    for (n = 0; n < 40 && i_done[k]; n++)
      @(negedge i_clk_sys);
    // Words no longer owned by a request are scrambled so stale values cannot pass.
    {o_sel, o_spd, o_cmd, o_arg} = ~{o_sel, o_spd, o_cmd, o_arg};
  endtask
endmodule // frwh_master_model

// ==== testbench/frwh_remote_words_bench.sv ====
`timescale 1ns/1ps
module frwh_remote_words_bench;
  logic i_clk_sys, i_arst_n, enc_a, enc_b, link_en, save;
  logic [15:0] sel, spd, cmd, arg, mspd, mon_res, rsp, res, setpt, mode, last_spd, v, pwd;
  logic [7:0] pwa, ext;
  logic [15:0] dq [11];
  logic [15:0] hist [4];
  logic [2:0] req, done, seen, prev;
  logic [15:0] q_mon [$];
  logic [15:0] q_spd [$];
  logic [32:0] q_cmd [$];
  int n_fail, num_checks, k;
  localparam logic [15:0] MCODE [11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0006, 16'h0007,
    16'h0008, 16'h000E, 16'h000F, 16'h0010, 16'h0011, 16'h0012};
  frwh_remote_words #(.HOUR_CYCLES(16)) frwh_remote_words_i (.i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n), .i_monitor_selector(sel), .i_speed_reference(spd),
    .i_command_select(cmd), .i_command_argument(arg), .i_monitor_request(req[0]),
    .i_speed_write_request(req[1]), .i_cmd_exec_request(req[2]), .i_out_freq(dq[0]),
    .i_out_curr(dq[1]), .i_out_volt(dq[2]), .i_op_speed_rpm(dq[3]), .i_torque_cmd(dq[4]),
    .i_dc_bus(dq[5]), .i_motor_pwr(dq[6]), .i_op_cmd_bits(dq[7]), .i_out_term_bits(dq[8]),
    .i_torque_curr_cmd(dq[9]), .i_flux_cmd(dq[10]), .i_motor_speed_scaled(mspd),
    .i_enc_a(enc_a), .i_enc_b(enc_b), .i_link_enable(link_en), .i_alarm_hist_0(hist[0]),
    .i_alarm_hist_1(hist[1]), .i_alarm_hist_2(hist[2]), .i_alarm_hist_3(hist[3]),
    .i_save_all_params(save), .o_monitored_result(mon_res), .o_actual_speed(),
    .o_command_response(rsp), .o_command_result(res), .o_monitor_done(done[0]),
    .o_speed_write_done(done[1]), .o_cmd_exec_done(done[2]), .o_speed_setpoint(setpt),
    .o_operating_mode(mode), .o_alarm_reset(), .o_save_strobe(), .o_param_wr_data(pwd),
    .o_param_wr_addr(pwa), .o_link_param_ext(ext));
  frwh_master_model frwh_master_model_i (.i_clk_sys(i_clk_sys), .i_done(done), .o_sel(sel),
    .o_spd(spd), .o_cmd(cmd), .o_arg(arg), .o_req(req));
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic mon(input logic [15:0] c, input logic [15:0] e);
    q_mon.push_back(e);
    frwh_master_model_i.xfer(0, c, 16'h0000, $urandom_range(0, 3));
  endtask
  task automatic spdw(input int s);
    last_spd = 16'(s > 20000 ? 20000 : (s < -20000 ? -20000 : s));
    q_spd.push_back(last_spd);
    frwh_master_model_i.xfer(1, 16'(s), 16'h0000, $urandom_range(0, 3));
  endtask
  // With care low only the response code is judged, the result word being undefined.
  task automatic run(input logic [15:0] c, input logic [15:0] a, input logic care,
    input logic [15:0] r, input logic [15:0] d);
    q_cmd.push_back({care, r, d});
    frwh_master_model_i.xfer(2, c, a, $urandom_range(0, 3));
  endtask
  task automatic results();
    if (q_mon.size() + q_spd.size() + q_cmd.size() != 0)
      n_fail++;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Results are judged two edges after a done bit rises, while the done bit is still high.
  always @(posedge i_clk_sys)
  begin
    if (seen[0])
      chk(q_mon.pop_front(), mon_res);
    if (seen[1])
      chk(q_spd.pop_front(), setpt);
    if (seen[2] && q_cmd[0][32])
      chk(q_cmd[0][31:0], {rsp, res});
    else if (seen[2])
      chk(q_cmd[0][31:16], rsp);
    if (seen[2])
      q_cmd.pop_front();
    seen = done & ~prev;
    prev = done;
  end
  always @(negedge i_clk_sys)
    mspd <= 16'($urandom);
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    #(5 * 20000);
    n_fail++;
    results();
  end
  initial
  begin
    {i_arst_n, enc_a, enc_b, save, seen, prev} = '0;
    link_en = 1'b1;
    v = 16'($urandom(86));
    foreach (dq[i]) dq[i] = 16'($urandom);
    foreach (hist[i]) hist[i] = 16'($urandom);
    repeat (10) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    for (k = 0; k < 8; k++)
    begin
      @(negedge i_clk_sys);
      {enc_a, enc_b} = {k[1] ^ k[0], ~k[1]};
    end
    repeat (4) @(negedge i_clk_sys);
    mon(16'h0013, 16'h0008);
    for (k = 0; k < 26; k++)
      if (k == 0 || k == 4 || (k >= 9 && k <= 13) || k >= 21)
        mon(16'(k), 16'h0000);
    for (k = 0; k < 11; k++)
      mon(MCODE[k], dq[k]);
    foreach (MCODE[i]) spdw(i == 10 ? $urandom_range(0, 60000) - 30000 : (i - 5) * 5000);
    k = $urandom_range(0, 99);
    run(16'h0080 + 16'(k), v, 1'b0, 16'h0000, 16'h0000);
    chk({8'(k), v}, {pwa, pwd});
    run(16'(k), 16'h0000, 1'b1, 16'h0000, v);
    run(16'h0070, 16'h0000, 1'b1, 16'h0001, v);
    run(16'h00FD, 16'h1234, 1'b1, 16'h0002, v);
    link_en = 1'b0;
    run(16'h00FD, 16'h9696, 1'b1, 16'h0003, v);
    link_en = 1'b1;
    run(16'h00FD, 16'h9696, 1'b0, 16'h0000, 16'h0000);
    for (k = 0; k < 4; k++)
      run(16'h0074 + 16'(k), 16'h0000, 1'b1, 16'h0000, hist[k]);
    run(16'h006D, 16'h0000, 1'b1, 16'h0000, last_spd);
    run(16'h00FB, 16'h0001, 1'b0, 16'h0000, 16'h0000);
    chk(16'h0001, mode);
    run(16'h007B, 16'h0000, 1'b1, 16'h0000, 16'h0001);
    run(16'h00FF, 16'h0001, 1'b0, 16'h0000, 16'h0000);
    chk(16'h0001, ext);
    run(16'h007F, 16'h0000, 1'b1, 16'h0000, 16'h0001);
    run(16'h00FF, 16'h0100, 1'b1, 16'h0002, 16'h0001);
    run(16'h0080 + 16'(k), ~v, 1'b0, 16'h0000, 16'h0000);
    chk({8'h80 | 8'(k), ~v}, {pwa, pwd});
    run(16'(k), 16'h0000, 1'b1, 16'h0000, ~v);
    run(16'h00ED, 16'h1388, 1'b0, 16'h0000, 16'h0000);
    mon(16'h0005, 16'h1388);
    run(16'h00ED, 16'h8000, 1'b1, 16'h0002, 16'h0000);
    run(16'h00FB, 16'h0002, 1'b1, 16'h0002, 16'h0000);
    // A second reset restarts the hour count, so the hour monitor has a known value.
    i_arst_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    repeat (50) @(negedge i_clk_sys);
    mon(16'h0014, 16'h0003);
    run(16'h007B, 16'h0000, 1'b1, 16'h0000, 16'h0000);
    save = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    save = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    results();
  end
endmodule // frwh_remote_words_bench
